// *** shared/ast_params.svh ***
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH
`define AST_OVERSAMPLE      5'd16
`define AST_HALF_BIT        5'd8
`define AST_RESET_WAIT      5'd18
`define AST_LEN_5           2'b00
`define AST_FIFO_DEPTH      4
`define AST_DATA_W          8
`endif

// *** shared/ast_pkg.sv ***
package ast_pkg;
    typedef enum logic [2:0] {
        AST_IDLE   = 3'b000,
        AST_START  = 3'b001,
        AST_DATA   = 3'b010,
        AST_PARITY = 3'b011,
        AST_STOP   = 3'b100
    } ast_state_e;
    typedef logic [7:0] ast_char_t;
endpackage

// *** rtl/ast_fifo.sv ***
`timescale 1ns/1ns
module ast_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// *** rtl/ast_tick.sv ***
`timescale 1ns/1ns
module ast_tick (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Shift clock level and its rising-edge pulse.
    input  wire logic shift_clock,
    output logic      tick
);
    logic prev;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else begin
            prev <= shift_clock;
        end
    end

    assign tick = shift_clock && !prev;
endmodule

// *** rtl/ast_tx.sv ***
`timescale 1ns/1ns
`include "ast_params.svh"
// Summary of operation
// RULE1: Buffer-empty high once character moved to shifter.
// RULE2: Low load strobe captures parallel data.
// RULE3: Strobe rise starts move; waits if busy.
// RULE4: Shifter-empty rises after final stop bit.
// RULE5: Start, data, stop bits on one output.
// RULE6: Short words ignore upper data inputs.
// RULE7: Data input bit one is LSB.
// RULE8: Format latch follows while load high.
// RULE9: Parity inhibit omits parity, forces error low.
// RULE10: Stop select gives 1.5 or 2 stops.
// RULE11: Length selects choose 5 to 8 bits.
// RULE12: Parity sense high even, low odd.
// RULE13: Each bit lasts sixteen shift clocks.
// RULE14: Strobe rise clears buffer-empty flag.
// RULE15: Idle shifter loads within one shift clock.
// RULE16: Waiting character starts after current finishes.
// RULE17: Master reset; shifter-empty after 18 clocks.
// RULE18: Status disable floats buffer-empty flag.
// RULE19: Idle high, start low, LSB first.
// RULE20: Host loads only while buffer empty; the FIFO here accepts loads whenever TX_LOAD_READY is high.
module ast_tx #(
    parameter int DATA_W     = `AST_DATA_W,
    parameter int FIFO_DEPTH = `AST_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic             MCLK,
    input  wire logic             RST_B,
    input  wire logic             MASTER_RESET,
    input  wire logic             TX_SHIFT_CLOCK,
    // Parallel load.
    input  wire ast_pkg::ast_char_t TX_PARALLEL_DATA,
    input  wire logic             TX_BUFFER_LOAD_N,
    output logic                  TX_LOAD_READY,
    // Format control.
    input  wire logic             FORMAT_LATCH_LOAD,
    input  wire logic             PARITY_INHIBIT,
    input  wire logic             STOP_SELECT,
    input  wire logic             LENGTH_SELECT1,
    input  wire logic             LENGTH_SELECT2,
    input  wire logic             PARITY_SENSE,
    // Status.
    input  wire logic             STATUS_DISABLE,
    output logic                  TX_BUFFER_EMPTY,
    output logic                  TX_BUFFER_EMPTY_OE,
    output logic                  TX_SHIFTER_EMPTY,
    output logic                  PARITY_ERROR,
    output logic                  PARITY_ERROR_OE,
    // Serial line.
    output logic                  TX_SERIAL_OUT
);
    import ast_pkg::*;

    // ----------------------------------------------------------------
    // Format latch and strobe edge.
    // ----------------------------------------------------------------
    logic       fmt_pi;
    logic       fmt_sbs;
    logic [1:0] fmt_len;
    logic       fmt_even;
    logic       cur_pi;
    logic       cur_sbs;
    logic [1:0] cur_len;
    logic       cur_even;
    logic       load_prev;
    logic       load_rise;
    logic       tick;
    logic       run_rst;
    ast_char_t  buf_data;

    assign run_rst = !RST_B || MASTER_RESET;

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            fmt_pi   <= 1'b0;
            fmt_sbs  <= 1'b0;
            fmt_len  <= 2'b00;
            fmt_even <= 1'b0;
        end else if (FORMAT_LATCH_LOAD) begin // RULE8
            fmt_pi   <= PARITY_INHIBIT;
            fmt_sbs  <= STOP_SELECT;
            fmt_len  <= {LENGTH_SELECT2, LENGTH_SELECT1}; // RULE11
            fmt_even <= PARITY_SENSE;
        end
    end

    // Transparent while the load input is high.
    assign cur_pi   = FORMAT_LATCH_LOAD ? PARITY_INHIBIT : fmt_pi;
    assign cur_sbs  = FORMAT_LATCH_LOAD ? STOP_SELECT : fmt_sbs;
    assign cur_len  = FORMAT_LATCH_LOAD ? {LENGTH_SELECT2, LENGTH_SELECT1} : fmt_len;
    assign cur_even = FORMAT_LATCH_LOAD ? PARITY_SENSE : fmt_even;

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            load_prev <= 1'b1;
        end else begin
            load_prev <= TX_BUFFER_LOAD_N;
        end
    end

    assign load_rise = TX_BUFFER_LOAD_N && !load_prev; // RULE3

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            buf_data <= '0;
        end else if (!TX_BUFFER_LOAD_N) begin
            buf_data <= TX_PARALLEL_DATA; // RULE2
        end
    end

    ast_tick u_tick (
        .clk         (MCLK),
        .rst_b       (RST_B),
        .shift_clock (TX_SHIFT_CLOCK),
        .tick        (tick)
    );

    // ----------------------------------------------------------------
    // Holding FIFO.
    // ----------------------------------------------------------------
    logic      fifo_in_valid;
    logic      fifo_out_valid;
    logic      fifo_out_ready;
    ast_char_t fifo_out_data;
    logic      fifo_in_ready;

    assign fifo_in_valid = load_rise;
    assign TX_LOAD_READY = fifo_in_ready;

    ast_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst_b     (!run_rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (buf_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ----------------------------------------------------------------
    // Shifter.
    // ----------------------------------------------------------------
    ast_state_e state;
    ast_char_t  shift;
    logic [4:0] sub;
    logic [2:0] bit_idx;
    logic [2:0] last_bit;
    logic       stop_second;
    logic       parity;
    logic       half_stop;
    logic [4:0] rst_wait;
    logic       ready_run;

    assign last_bit  = 3'd4 + {1'b0, cur_len}; // RULE11
    assign half_stop = (cur_len == `AST_LEN_5);
    assign fifo_out_ready = tick && ready_run && (state == AST_IDLE); // RULE15 RULE16

    always_ff @(posedge MCLK) begin
        if (run_rst) begin
            rst_wait <= '0;
        end else if (rst_wait != `AST_RESET_WAIT) begin
            rst_wait <= rst_wait + 5'd1; // RULE17
        end
    end

    assign ready_run = (rst_wait == `AST_RESET_WAIT);

    always_ff @(posedge MCLK) begin
        if (run_rst) begin
            state       <= AST_IDLE;
            shift       <= '0;
            sub         <= '0;
            bit_idx     <= '0;
            stop_second <= 1'b0;
            parity      <= 1'b0;
        end else if (tick) begin
            case (state)
                AST_IDLE: begin
                    if (fifo_out_valid && ready_run) begin
                        // Mask unused upper bits for short words.
                        for (int i = 0; i < 8; i++) begin
                            shift[i] <= fifo_out_data[i] && (3'(i) <= last_bit); // RULE6 RULE7
                        end
                        parity      <= ^fifo_out_data;
                        sub         <= '0;
                        bit_idx     <= '0;
                        stop_second <= 1'b0;
                        state       <= AST_START;
                    end
                end
                AST_START: begin
                    sub <= sub + 5'd1;
                    if (sub == `AST_OVERSAMPLE - 5'd1) begin // RULE13
                        sub   <= '0;
                        state <= AST_DATA;
                        parity <= ^shift;
                    end
                end
                AST_DATA: begin
                    sub <= sub + 5'd1;
                    if (sub == `AST_OVERSAMPLE - 5'd1) begin
                        sub     <= '0;
                        shift   <= {1'b0, shift[7:1]};
                        bit_idx <= bit_idx + 3'd1;
                        if (bit_idx == last_bit) begin
                            state <= cur_pi ? AST_STOP : AST_PARITY; // RULE9
                        end
                    end
                end
                AST_PARITY: begin
                    sub <= sub + 5'd1;
                    if (sub == `AST_OVERSAMPLE - 5'd1) begin
                        sub   <= '0;
                        state <= AST_STOP;
                    end
                end
                AST_STOP: begin
                    sub <= sub + 5'd1;
                    if (!stop_second && sub == `AST_OVERSAMPLE - 5'd1) begin
                        sub <= '0;
                        if (cur_sbs) begin
                            stop_second <= 1'b1; // RULE10
                        end else begin
                            state <= AST_IDLE;
                        end
                    end else if (stop_second && (half_stop ? sub == `AST_HALF_BIT - 5'd1
                                                           : sub == `AST_OVERSAMPLE - 5'd1)) begin
                        sub         <= '0;
                        stop_second <= 1'b0;
                        state       <= AST_IDLE;
                    end
                end
                default: begin
                    state <= AST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (run_rst) begin
            TX_SERIAL_OUT <= 1'b1;
        end else begin
            case (state)
                AST_START:  TX_SERIAL_OUT <= 1'b0; // RULE19 RULE5
                AST_DATA:   TX_SERIAL_OUT <= shift[0];
                AST_PARITY: TX_SERIAL_OUT <= parity ^ !cur_even; // RULE12
                default:    TX_SERIAL_OUT <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (run_rst) begin
            TX_SHIFTER_EMPTY <= 1'b0;
        end else begin
            TX_SHIFTER_EMPTY <= ready_run && (state == AST_IDLE) && !fifo_out_valid; // RULE4
        end
    end

    always_ff @(posedge MCLK) begin
        if (run_rst) begin
            TX_BUFFER_EMPTY <= 1'b1;
        end else if (load_rise) begin
            TX_BUFFER_EMPTY <= 1'b0; // RULE14
        end else if (!fifo_out_valid) begin
            TX_BUFFER_EMPTY <= 1'b1; // RULE1
        end
    end

    assign TX_BUFFER_EMPTY_OE = !STATUS_DISABLE; // RULE18
    assign PARITY_ERROR       = 1'b0; // RULE9
    assign PARITY_ERROR_OE    = !STATUS_DISABLE;

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    sequence s_start_taken;
        tick && state == AST_IDLE && fifo_out_valid && ready_run;
    endsequence

    AST_START_LOW: assert property (@(posedge MCLK) disable iff (run_rst) // RULE5
        s_start_taken |=> ##1 !TX_SERIAL_OUT)
        else $error("start bit not low");
    AST_IDLE_HIGH: assert property (@(posedge MCLK) disable iff (run_rst) // RULE19
        $past(state) == AST_IDLE && state == AST_IDLE |=> TX_SERIAL_OUT)
        else $error("line not idle high");
    AST_BE_CLEAR: assert property (@(posedge MCLK) disable iff (run_rst) // RULE14
        load_rise |=> !TX_BUFFER_EMPTY)
        else $error("buffer empty not cleared");
    AST_SE_LOW: assert property (@(posedge MCLK) disable iff (run_rst) // RULE4
        state != AST_IDLE |=> !TX_SHIFTER_EMPTY)
        else $error("shifter empty during frame");
    AST_PE_LOW: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE9
        !PARITY_ERROR)
        else $error("parity error high");
    AST_SUB_RANGE: assert property (@(posedge MCLK) disable iff (run_rst) // RULE13
        sub < `AST_OVERSAMPLE)
        else $error("bit counter overflow");
    AST_OE_FOLLOW: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE18
        STATUS_DISABLE |-> !TX_BUFFER_EMPTY_OE)
        else $error("status drive while disabled");
    AST_RST_WAIT: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE17
        $fell(MASTER_RESET) |-> !TX_SHIFTER_EMPTY [*8])
        else $error("shifter empty too early");
    AST_LATCH: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE8
        FORMAT_LATCH_LOAD |=> fmt_sbs == $past(STOP_SELECT))
        else $error("format latch not following");
endmodule

// *** verif/ast_rx_model.sv ***
`timescale 1ns/1ns
module ast_rx_model (
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // Serial line and its shift clock.
    input  wire logic        SHIFT_CLOCK,
    input  wire logic        LINE,
    // Format that the receiver expects.
    input  wire logic [3:0]  LEN,
    input  wire logic        PAR_ON,
    input  wire logic        TWO_STOP,
    // Received frame.
    output logic             FRAME_VALID = 1'b0,
    output logic [7:0]       FRAME_DATA = 8'h00,
    output logic             FRAME_PAR = 1'b0,
    output logic             FRAME_OK = 1'b0,
    output logic [15:0]      FRAME_GAP = 16'h0000
);
    // ----------------------------------------------------------------
    // Mid-bit sampling receiver.
    // ----------------------------------------------------------------
    logic        sc_q = 1'b0;
    logic        line_q = 1'b1;
    logic        busy = 1'b0;
    logic [11:0] bits = 12'h000;
    int          tk = 0;
    int          idx = 0;
    int          gap = 0;

    always @(posedge MCLK) begin : rx
        logic [11:0] b;
        logic        tick;
        logic        detect;
        int          nb;
        int          last;
        tick = SHIFT_CLOCK & ~sc_q;
        detect = !busy && line_q && !LINE;
        nb = 2 + int'(LEN) + int'(PAR_ON);
        last = 8 + 16 * (nb - 1) + (TWO_STOP ? ((LEN == 4'h5) ? 12 : 16) : 0);
        b = bits;
        sc_q <= SHIFT_CLOCK;
        line_q <= LINE;
        FRAME_VALID <= 1'b0;
        if (!RST_B) begin
            busy <= 1'b0;
            gap = 0;
        end else if (detect) begin
            busy <= 1'b1;
            tk <= 0;
            idx <= 0;
            FRAME_GAP <= 16'(gap);
            gap = int'(tick);
        end else begin
            gap = gap + int'(tick);
            if (busy && tick) begin
                if (tk == 8 + 16 * idx && idx < nb) begin
                    b[idx] = LINE;
                    idx <= idx + 1;
                end
                if (tk == last) begin
                    FRAME_VALID <= 1'b1;
                    FRAME_OK <= !b[0] && b[nb-1] && LINE;
                    FRAME_PAR <= PAR_ON ? b[LEN+1] : 1'b0;
                    for (int i = 0; i < 8; i++) begin
                        FRAME_DATA[i] <= (i < int'(LEN)) ? b[i+1] : 1'b0;
                    end
                    busy <= 1'b0;
                end
                tk <= tk + 1;
            end
        end
        bits <= b;
    end
endmodule

// *** verif/tb_async_serial_transmitter.sv ***
`timescale 1ns/1ns
`include "ast_params.svh"
module tb_async_serial_transmitter;
    import ast_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances.
    // ----------------------------------------------------------------
    logic        MCLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        MASTER_RESET = 1'b0;
    logic        TX_SHIFT_CLOCK = 1'b0;
    ast_char_t   TX_PARALLEL_DATA = 8'h00;
    logic        TX_BUFFER_LOAD_N = 1'b1;
    logic        FORMAT_LATCH_LOAD = 1'b1;
    logic        STATUS_DISABLE = 1'b0;
    logic [4:0]  fmt = 5'h00;
    logic        TX_LOAD_READY, TX_BUFFER_EMPTY, TX_BUFFER_EMPTY_OE, TX_SHIFTER_EMPTY;
    logic        PARITY_ERROR, PARITY_ERROR_OE, TX_SERIAL_OUT;
    logic        rx_valid, rx_par, rx_ok;
    logic [7:0]  rx_data;
    logic [15:0] rx_gap;
    int          m_len = 5;
    logic        m_pi = 1'b0;
    logic        m_sbs = 1'b0;
    logic        m_ev = 1'b0;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          n;
    logic [24:0] exp_q[$];
    logic [24:0] e;

    ast_tx ast_tx_inst (.MCLK(MCLK), .RST_B(RST_B), .MASTER_RESET(MASTER_RESET),
        .TX_SHIFT_CLOCK(TX_SHIFT_CLOCK), .TX_PARALLEL_DATA(TX_PARALLEL_DATA),
        .TX_BUFFER_LOAD_N(TX_BUFFER_LOAD_N), .TX_LOAD_READY(TX_LOAD_READY),
        .FORMAT_LATCH_LOAD(FORMAT_LATCH_LOAD), .PARITY_INHIBIT(fmt[2]), .STOP_SELECT(fmt[3]),
        .LENGTH_SELECT1(fmt[0]), .LENGTH_SELECT2(fmt[1]), .PARITY_SENSE(fmt[4]),
        .STATUS_DISABLE(STATUS_DISABLE), .TX_BUFFER_EMPTY(TX_BUFFER_EMPTY),
        .TX_BUFFER_EMPTY_OE(TX_BUFFER_EMPTY_OE), .TX_SHIFTER_EMPTY(TX_SHIFTER_EMPTY),
        .PARITY_ERROR(PARITY_ERROR), .PARITY_ERROR_OE(PARITY_ERROR_OE),
        .TX_SERIAL_OUT(TX_SERIAL_OUT));
    ast_rx_model ast_rx_model_inst (.MCLK(MCLK), .RST_B(RST_B & ~MASTER_RESET),
        .SHIFT_CLOCK(TX_SHIFT_CLOCK), .LINE(TX_SERIAL_OUT), .LEN(4'(m_len)), .PAR_ON(!m_pi),
        .TWO_STOP(m_sbs), .FRAME_VALID(rx_valid), .FRAME_DATA(rx_data), .FRAME_PAR(rx_par),
        .FRAME_OK(rx_ok), .FRAME_GAP(rx_gap));

    always #25 MCLK = ~MCLK;
    always @(negedge MCLK) TX_SHIFT_CLOCK <= ~TX_SHIFT_CLOCK;

    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    task automatic chk_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wait_cnt(input int which, input logic lvl, input int lim);
        int i;
        i = 0;
        while (((which == 0) ? TX_SHIFTER_EMPTY : TX_BUFFER_EMPTY) !== lvl && i < lim) begin
            @(negedge MCLK);
            i++;
        end
        chk_flag((which == 0) ? TX_SHIFTER_EMPTY : TX_BUFFER_EMPTY, lvl);
    endtask
    task automatic settle();
        repeat (17) @(negedge MCLK);
        chk_flag(TX_SHIFTER_EMPTY, 1'b0);
        wait_cnt(0, 1'b1, 8);
        chk_flag(TX_SERIAL_OUT, 1'b1);
    endtask
    task automatic set_fmt(input logic [4:0] f, input bit both);
        @(negedge MCLK);
        fmt = f;
        if (both) begin
            m_len = 5 + int'(f[1:0]);
            m_pi = f[2];
            m_sbs = f[3];
            m_ev = f[4];
        end
    endtask
    task automatic strobe(input ast_char_t d);
        @(negedge MCLK);
        TX_BUFFER_LOAD_N = 1'b0;
        TX_PARALLEL_DATA = d;
        @(negedge MCLK);
        TX_BUFFER_LOAD_N = 1'b1;
        repeat (2) @(negedge MCLK);
    endtask
    function automatic logic [15:0] fticks();
        // A queued character starts one shift tick after the previous frame ends.
        return 16'(16 * (1 + m_len + int'(!m_pi)) + (m_sbs ? ((m_len == 5) ? 24 : 32) : 16) + 1);
    endfunction
    task automatic send(input ast_char_t d, input bit b2b);
        ast_char_t m;
        logic      p;
        m = d & (8'hff >> (8 - m_len));
        p = m_pi ? 1'b0 : (m_ev ? ^m : ~^m);
        if (!b2b) wait_cnt(1, 1'b1, 40);
        exp_q.push_back({b2b ? fticks() : 16'h0, p, m});
        strobe(d);
        if (b2b) chk_flag(TX_BUFFER_EMPTY, 1'b0);
        else begin
            wait_cnt(0, 1'b0, 10);
            wait_cnt(1, 1'b1, 10);
        end
    endtask

    // ----------------------------------------------------------------
    // Result watcher, stimulus and watchdog.
    // ----------------------------------------------------------------
    always @(negedge MCLK) begin
        if (rx_valid === 1'b1) begin
            chk_flag(exp_q.size() > 0, 1'b1);
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk_val({7'h0, rx_par, rx_data}, {7'h0, e[8:0]});
                chk_flag(rx_ok, 1'b1);
                if (e[24:9] != 16'h0) chk_val(rx_gap, e[24:9]);
                chk_flag(TX_SHIFTER_EMPTY, 1'b0);
                chk_flag(PARITY_ERROR, 1'b0);
            end
        end
    end

    initial begin
        void'($urandom(61));
        repeat (6) @(negedge MCLK);
        chk_flag(TX_SERIAL_OUT, 1'b1);
        chk_flag(TX_SHIFTER_EMPTY, 1'b0);
        RST_B = 1'b1;
        settle();
        for (int f = 0; f < 32; f++) begin
            set_fmt(5'(f), 1'b1);
            send(ast_char_t'($urandom), 1'b0);
            send(ast_char_t'($urandom), 1'b1);
            wait_cnt(0, 1'b1, 900);
            chk_val(16'(exp_q.size()), 16'h0);
        end
        set_fmt(5'h07, 1'b1);
        n = 0;
        while (TX_LOAD_READY === 1'b1 && n < 8) begin
            send(ast_char_t'($urandom), n > 0);
            n++;
        end
        chk_val(16'(n), 16'(`AST_FIFO_DEPTH + 1));
        strobe(8'h5a);
        wait_cnt(0, 1'b1, 3000);
        chk_val(16'(exp_q.size()), 16'h0);
        strobe(8'h3c);
        repeat (40) @(negedge MCLK);
        MASTER_RESET = 1'b1;
        repeat (3) @(negedge MCLK);
        MASTER_RESET = 1'b0;
        settle();
        set_fmt(5'h13, 1'b1);
        @(negedge MCLK);
        FORMAT_LATCH_LOAD = 1'b0;
        set_fmt(5'h0c, 1'b0);
        send(ast_char_t'($urandom), 1'b0);
        wait_cnt(0, 1'b1, 900);
        chk_val(16'(exp_q.size()), 16'h0);
        FORMAT_LATCH_LOAD = 1'b1;
        STATUS_DISABLE = 1'b1;
        @(negedge MCLK);
        chk_flag(TX_BUFFER_EMPTY_OE, 1'b0);
        chk_flag(PARITY_ERROR_OE, 1'b0);
        STATUS_DISABLE = 1'b0;
        @(negedge MCLK);
        chk_flag(TX_BUFFER_EMPTY_OE, 1'b1);
        finish_test();
    end

    initial begin
        repeat (80000) @(posedge MCLK);
        n_mismatch++;
        finish_test();
    end
endmodule
